// file: core/dfs_stream_readout.sv
// Purpose : Extended-feature result readout, by register and by stream scan list
// Assumes : Feature cores run on sys_clk and present 32-bit results per line
// Notes   : Zero-wait AHB-Lite slave; stream answers pass a two-entry buffer
`timescale 1ns/1ps
module dfs_stream_readout
  import dfs_pkg::*;
#(
  parameter int NUM_LINES = 23
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output      logic                 hreadyout,
  output      logic                 hresp,
  output      logic [31:0]          hrdata,
  // Feature cores
  input  wire logic [31:0]          resultA [NUM_LINES],
  input  wire logic [31:0]          resultB [NUM_LINES],
  output      logic [NUM_LINES-1:0] featureClear,
  output      logic [NUM_LINES-1:0] lineEnable,
  output      logic [3:0]           lineFeature [NUM_LINES],
  // Stream scan-list requests
  input  wire logic                 entryValid,
  output      logic                 entryReady,
  input  wire logic [1:0]           entryKind,
  input  wire logic [4:0]           entryLine,
  // Stream answers
  output      logic                 wordValid,
  input  wire logic                 wordReady,
  output      logic [15:0]          wordData,
  output      logic                 wordRefused
);

  localparam int LW = 5;

  function automatic logic isStreamable(input logic [3:0] f);
    isStreamable = (f == DFS_FEAT_FREQ_IN_A)  || (f == DFS_FEAT_FREQ_IN_B)
                || (f == DFS_FEAT_PULSE_W_IN) || (f == DFS_FEAT_HS_COUNTER)
                || (f == DFS_FEAT_IRQ_COUNT)  || (f == DFS_FEAT_IRQ_CNT_DB)
                || (f == DFS_FEAT_QUADRATURE) || (f == DFS_FEAT_IRQ_FREQ);
  endfunction

  function automatic logic isTwoLine(input logic [3:0] f);
    isTwoLine = (f == DFS_FEAT_LINE2LINE) || (f == DFS_FEAT_QUADRATURE);
  endfunction

  // Registers
  logic [LW-1:0]          selLine_q;
  logic [3:0]             featIdx_q [NUM_LINES];
  logic [NUM_LINES-1:0]   enable_q;
  logic [DFS_HALF_W-1:0]  capture_q;
  logic                   cfgRefused_q;
  logic                   strRefused_q;
  logic [31:0]            hrdata_q;
  logic                   wrPend_q;
  logic [7:0]             wrAddr_q;

  // Lines held as the second line of an enabled two-line feature
  logic [NUM_LINES-1:0]   takenByPair;
  always_comb begin
    takenByPair = '0;
    for (int i = 1; i < NUM_LINES; i++) begin
      takenByPair[i] = enable_q[i-1] && isTwoLine(featIdx_q[i-1]);
    end
  end

  // Address phase
  wire        busAccept = hsel && hready && htrans[1];
  wire        rdAccept  = busAccept && !hwrite;
  wire [7:0]  addrOfs   = haddr[7:0];
  wire        addrHit   = (haddr[31:8] == 24'h00_0000) && (addrOfs[1:0] == 2'b00);

  // Data phase write decode
  wire        wrLineSel = wrPend_q && (wrAddr_q == DFS_OFS_LINE_SEL);
  wire        wrFeatIdx = wrPend_q && (wrAddr_q == DFS_OFS_FEAT_IDX);
  wire        wrEnable  = wrPend_q && (wrAddr_q == DFS_OFS_ENABLE);
  wire        wrStatus  = wrPend_q && (wrAddr_q == DFS_OFS_STATUS);

  wire [LW-1:0] selIdx  = selLine_q;
  wire          selLast = (selIdx == LW'(NUM_LINES - 1));
  wire [LW-1:0] partner = selLast ? selIdx : selIdx + LW'(1);
  wire [3:0]    selFeat = featIdx_q[selIdx];

  // Feature index may change only while the line is idle
  wire featOk  = !enable_q[selIdx] && (hwdata[3:0] < DFS_FEAT_LAST)
              && (hwdata[31:4] == 28'h000_0000);
  // A two-line feature needs a free partner line above it; re-enabling an
  // already running pair is harmless and must not be flagged as refused
  wire pairOk  = !isTwoLine(selFeat) || enable_q[selIdx]
              || (!selLast && !enable_q[partner]);
  wire enOk    = !takenByPair[selIdx] && pairOk;
  wire enSet   = wrEnable && hwdata[0];
  wire enClr   = wrEnable && !hwdata[0];
  wire cfgFail = (wrFeatIdx && !featOk) || (enSet && !enOk);

  // Stream side
  wire            strPush   = entryValid && entryReady;
  wire [LW-1:0]   strLine   = entryLine;
  wire            strLineOk = (strLine < LW'(NUM_LINES));
  wire [LW-1:0]   strIdx    = strLineOk ? strLine : '0;
  wire            isCapEnt  = (entryKind == DFS_ENT_CAPTURE);
  wire            strOk     = isCapEnt
                           || (strLineOk && enable_q[strIdx]
                               && isStreamable(featIdx_q[strIdx]));
  wire [31:0]     strValue  = (entryKind == DFS_ENT_RESULT_B) ? resultB[strIdx]
                                                              : resultA[strIdx];
  wire [DFS_HALF_W-1:0] strWord = !strOk   ? '0
                               : isCapEnt ? capture_q
                               : strValue[DFS_HALF_W-1:0];
  wire            strCapture = strPush && strOk && !isCapEnt;
  wire            strClr     = strPush && strOk && (entryKind == DFS_ENT_RES_A_CLR);

  // Bus read-and-clear
  wire            busClr = rdAccept && addrHit && (addrOfs == DFS_OFS_RES_A_CLR)
                        && enable_q[selIdx];

  always_comb begin
    featureClear = '0;
    if (strClr) begin
      featureClear[strIdx] = 1'b1;
    end
    if (busClr) begin
      featureClear[selIdx] = 1'b1;
    end
  end

  // Register read mux, sampled at the address phase
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (addrHit) begin
      unique case (addrOfs)
        DFS_OFS_LINE_SEL:  rdMux = {{(32-LW){1'b0}}, selLine_q};
        DFS_OFS_FEAT_IDX:  rdMux = {28'h000_0000, selFeat};
        DFS_OFS_ENABLE:    rdMux = {30'h0000_0000, takenByPair[selIdx], enable_q[selIdx]};
        DFS_OFS_STATUS:    rdMux = {30'h0000_0000, strRefused_q, cfgRefused_q};
        DFS_OFS_RESULT_A:  rdMux = resultA[selIdx];
        DFS_OFS_RESULT_B:  rdMux = resultB[selIdx];
        DFS_OFS_RES_A_CLR: rdMux = resultA[selIdx];
        DFS_OFS_CAPTURE:   rdMux = {16'h0000, capture_q};
        default:           rdMux = 32'h0000_0000;
      endcase
    end
  end

  // Bus pipeline
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= busAccept && hwrite && addrHit;
      wrAddr_q <= addrOfs;
      if (rdAccept) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // Line select and status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      selLine_q    <= '0;
      cfgRefused_q <= 1'b0;
      strRefused_q <= 1'b0;
      capture_q    <= DFS_RST_CAPTURE;
    end else begin
      if (wrLineSel && (hwdata < 32'(NUM_LINES))) begin
        selLine_q <= hwdata[LW-1:0];
      end
      // A new event wins over a clear in the same cycle
      cfgRefused_q <= cfgFail
                   || (cfgRefused_q && !(wrStatus && hwdata[DFS_ST_CFG_REFUSED]));
      strRefused_q <= (strPush && !strOk)
                   || (strRefused_q && !(wrStatus && hwdata[DFS_ST_STR_REFUSED]));
      if (strCapture) begin
        capture_q <= strValue[31:DFS_HALF_W];
      end
    end
  end

  // Per-line configuration
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enable_q <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        featIdx_q[i] <= DFS_RST_FEAT;
      end
    end else begin
      if (wrFeatIdx && featOk) begin
        featIdx_q[selIdx] <= hwdata[3:0];
      end
      if (enSet && enOk) begin
        enable_q[selIdx] <= 1'b1;
      end else if (enClr) begin
        enable_q[selIdx] <= 1'b0;
      end
    end
  end

  // Stream answers; a stalled receiver backs up into entryReady
  logic [16:0] bufOut;
  dfs_skid2 #(
    .WIDTH (17)
  ) u_buf (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inValid  (entryValid),
    .inReady  (entryReady),
    .inData   ({!strOk, strWord}),
    .outValid (wordValid),
    .outReady (wordReady),
    .outData  (bufOut)
  );

  assign wordData    = bufOut[15:0];
  assign wordRefused = bufOut[16];
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_q;
  assign lineEnable  = enable_q;
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      lineFeature[i] = featIdx_q[i];
    end
  end

endmodule

// file: core/dfs_pkg.sv
// Purpose : Shared constants for the extended-feature stream readout block
// Assumes : AHB-Lite register access, one word per register
// Notes   : Feature codes follow the feature index values seen by software
package dfs_pkg;

  // Register byte offsets
  localparam logic [7:0] DFS_OFS_LINE_SEL  = 8'h00;
  localparam logic [7:0] DFS_OFS_FEAT_IDX  = 8'h04;
  localparam logic [7:0] DFS_OFS_ENABLE    = 8'h08;
  localparam logic [7:0] DFS_OFS_STATUS    = 8'h0C;
  localparam logic [7:0] DFS_OFS_RESULT_A  = 8'h10;
  localparam logic [7:0] DFS_OFS_RESULT_B  = 8'h14;
  localparam logic [7:0] DFS_OFS_RES_A_CLR = 8'h18;
  localparam logic [7:0] DFS_OFS_CAPTURE   = 8'h1C;

  // Status register fields
  localparam int DFS_ST_CFG_REFUSED = 0;
  localparam int DFS_ST_STR_REFUSED = 1;

  // Feature index codes
  localparam logic [3:0] DFS_FEAT_PWM_OUT    = 4'h0;
  localparam logic [3:0] DFS_FEAT_FREQ_IN_A  = 4'h3;
  localparam logic [3:0] DFS_FEAT_FREQ_IN_B  = 4'h4;
  localparam logic [3:0] DFS_FEAT_PULSE_W_IN = 4'h5;
  localparam logic [3:0] DFS_FEAT_LINE2LINE  = 4'h6;
  localparam logic [3:0] DFS_FEAT_HS_COUNTER = 4'h7;
  localparam logic [3:0] DFS_FEAT_IRQ_COUNT  = 4'h8;
  localparam logic [3:0] DFS_FEAT_IRQ_CNT_DB = 4'h9;
  localparam logic [3:0] DFS_FEAT_QUADRATURE = 4'hA;
  localparam logic [3:0] DFS_FEAT_IRQ_FREQ   = 4'hB;
  localparam logic [3:0] DFS_FEAT_LAST       = 4'hC;

  // Reset values
  localparam logic [3:0]  DFS_RST_FEAT    = 4'h0;
  localparam logic [15:0] DFS_RST_CAPTURE = 16'h0000;

  // Result split
  localparam int DFS_HALF_W = 16;

  // Scan-list entry kinds
  typedef enum logic [1:0] {
    DFS_ENT_RESULT_A  = 2'b00,
    DFS_ENT_RESULT_B  = 2'b01,
    DFS_ENT_RES_A_CLR = 2'b10,
    DFS_ENT_CAPTURE   = 2'b11
  } dfs_entry_t;

endpackage

// file: core/dfs_skid2.sv
// Purpose : Two-entry buffer with valid/ready on both sides
// Assumes : Single clock, synchronous active-low reset
// Notes   : Full-throughput; inReady is low only when both entries hold data
`timescale 1ns/1ps
module dfs_skid2 #(
  parameter int WIDTH = 17
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] mem_q [2];
  logic             rdPtr_q;
  logic             wrPtr_q;
  logic [1:0]       count_q;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign inReady  = (count_q != 2'd2);
  assign outValid = (count_q != 2'd0);
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
      count_q <= 2'd0;
    end else begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

endmodule

// file: verif/dfs_stream_readout_properties.sv
// Purpose: port checks for the stream readout
// Assumes: sees only the top module ports
// Notes: bound onto every instance of the block
`timescale 1ns/1ps
module dfs_stream_readout_properties #(
  parameter int NUM_LINES = 23
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [NUM_LINES-1:0] featureClear,
  input wire logic                 entryValid,
  input wire logic                 entryReady,
  input wire logic [1:0]           entryKind,
  input wire logic                 wordValid,
  input wire logic                 wordReady,
  input wire logic [15:0]          wordData,
  input wire logic                 wordRefused
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    entryValid && entryReady;
  endsequence
  sequence s_hold;
    wordValid && !wordReady;
  endsequence
  property p_zero_wait;
    hreadyout && !hresp;
  endproperty
  property p_answer;
    s_take |=> wordValid;
  endproperty
  property p_stall;
    s_hold |=> wordValid && $stable(wordData) && $stable(wordRefused);
  endproperty
  property p_refused_zero;
    wordValid && wordRefused |-> wordData == 16'h0000;
  endproperty
  property p_full;
    !entryReady |-> wordValid;
  endproperty
  property p_refill;
    !entryReady && wordReady |=> entryReady;
  endproperty
  property p_clear;
    featureClear != '0 |-> (entryValid && entryReady && entryKind == 2'b10)
      || (hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_0018);
  endproperty
  property p_out_of_reset;
    $rose(rst_n) |-> entryReady && !wordValid && featureClear == '0;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus wait or error");
  a_answer: assert property (p_answer) else $error("no answer word");
  a_stall: assert property (p_stall) else $error("word changed while stalled");
  a_refused_zero: assert property (p_refused_zero) else $error("refused word not 0");
  a_full: assert property (p_full) else $error("not ready with empty buffer");
  a_refill: assert property (p_refill) else $error("no room after drain");
  a_clear: assert property (p_clear) else $error("clear without cause");
  a_out_of_reset: assert property (p_out_of_reset) else $error("bad state after reset");
endmodule
bind dfs_stream_readout dfs_stream_readout_properties #(.NUM_LINES(NUM_LINES)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .featureClear(featureClear), .entryValid(entryValid), .entryReady(entryReady),
  .entryKind(entryKind), .wordValid(wordValid), .wordReady(wordReady),
  .wordData(wordData), .wordRefused(wordRefused));

// file: verif/dfs_host_model.sv
// Purpose: host collecting the scan-list stream
// Assumes: bench calls send and stop after a rising edge
// Notes: stall holds wordReady low; never enables timer features
`timescale 1ns/1ps
module dfs_host_model (
  input  wire logic        sys_clk,
  output      logic        entryValid,
  input  wire logic        entryReady,
  output      logic [1:0]  entryKind,
  output      logic [4:0]  entryLine,
  input  wire logic        wordValid,
  output      logic        wordReady,
  input  wire logic [15:0] wordData,
  input  wire logic        wordRefused
);
  logic        stall = 1'b0;
  logic        take = 1'b0;
  logic [16:0] seen;
  logic [16:0] got [$];
  initial begin
    entryValid = 1'b0;
    entryKind = 2'b00;
    entryLine = 5'h00;
    wordReady = 1'b1;
  end
  // Sampled mid-cycle so the edge's own updates never race the capture
  always @(negedge sys_clk) begin
    take = wordValid && wordReady;
    seen = {wordRefused, wordData};
  end
  always @(posedge sys_clk) begin
    if (take) got.push_back(seen);
    wordReady <= !stall;
  end
  // Entries go out in call order, capture right behind its result
  task automatic send(input logic [1:0] k, input logic [4:0] n);
    logic rdy;
    entryValid <= 1'b1;
    entryKind <= k;
    entryLine <= n;
    do begin
      @(negedge sys_clk) rdy = entryReady;
      @(posedge sys_clk);
    end while (!rdy);
  endtask
  // Released request lines show garbage, not the last entry
  task automatic stop();
    entryValid <= 1'b0;
    entryKind <= ~entryKind;
    entryLine <= ~entryLine;
  endtask
endmodule

// file: verif/dfs_stream_readout_tb.sv
// Purpose: self-checking bench for the stream readout
// Assumes: zero-wait bus slave, host model on the stream
// Notes: feature results are driven straight by the bench
`timescale 1ns/1ps
module dfs_stream_readout_tb;
  import dfs_pkg::*;
  localparam int NL = 23;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hready, hreadyout, hresp, entryValid, entryReady, wordValid, wordReady;
  logic        wordRefused;
  logic [31:0] hrdata, rdv;
  logic [31:0] resA [NL] = '{default: '0};
  logic [31:0] resB [NL] = '{default: '0};
  logic [1:0]  entryKind;
  logic [4:0]  entryLine;
  logic [15:0] wordData;
  logic [NL-1:0] clr, lineEn;
  logic [3:0]  lineFeat [NL];
  int          clrCnt [NL] = '{default: 0};
  logic [16:0] ex [6] = '{17'h0_1234, 17'h0_ABCD, 17'h0_9ABC, 17'h0_5678, 17'h0_1234,
                          17'h0_ABCD};
  int          badCount = 0;
  int          samplesChecked = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  dfs_stream_readout #(.NUM_LINES(NL)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .resultA(resA), .resultB(resB), .featureClear(clr), .lineEnable(lineEn),
    .lineFeature(lineFeat),
    .entryValid(entryValid), .entryReady(entryReady), .entryKind(entryKind),
    .entryLine(entryLine), .wordValid(wordValid), .wordReady(wordReady),
    .wordData(wordData), .wordRefused(wordRefused));
  dfs_host_model host (.sys_clk(sys_clk), .entryValid(entryValid), .entryReady(entryReady),
    .entryKind(entryKind), .entryLine(entryLine), .wordValid(wordValid),
    .wordReady(wordReady), .wordData(wordData), .wordRefused(wordRefused));
  initial forever #12.5 sys_clk = ~sys_clk;
  // Clear pulses last one cycle, so one mid-cycle look counts each once
  always @(negedge sys_clk) begin
    for (int i = 0; i < NL; i++) begin
      if (rst_n && clr[i]) clrCnt[i]++;
    end
  end
  task automatic endSim();
    $display("mismatches %0d checks %0d", badCount, samplesChecked);
    if (badCount == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      badCount++;
      endSim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(rdv, exp);
  endtask
  task automatic expw(input logic [16:0] exp);
    int n = 0;
    while (host.got.size() == 0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk(host.got.size() ? {15'h0000, host.got.pop_front()} : 32'hx, {15'h0000, exp});
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, then one unmapped word past the map
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], '0);
    resA[4] <= 32'h1357_2468;
    resB[4] <= 32'h1357_2468;
    wr(DFS_OFS_LINE_SEL, 4);
    for (int k = 0; k < 12; k++) begin
      wr(DFS_OFS_ENABLE, 0);
      wr(DFS_OFS_FEAT_IDX, k);
      wr(DFS_OFS_ENABLE, 1);
      host.send(2'(k % 3), 5'd4);
      host.stop();
      expw(k inside {0, 1, 2, 6} ? 17'h1_0000 : 17'h0_2468);
    end
    chk(clrCnt[4], 3);
    wr(DFS_OFS_ENABLE, 0);
    wr(DFS_OFS_FEAT_IDX, DFS_FEAT_QUADRATURE);
    wr(DFS_OFS_ENABLE, 1);
    wr(DFS_OFS_LINE_SEL, 5);
    wr(DFS_OFS_FEAT_IDX, DFS_FEAT_IRQ_COUNT);
    wr(DFS_OFS_FEAT_IDX, 12);
    rd(DFS_OFS_FEAT_IDX, DFS_FEAT_IRQ_COUNT);
    wr(DFS_OFS_ENABLE, 1);
    rd(DFS_OFS_ENABLE, 32'h0000_0002);
    chk({9'h000, lineEn}, 32'h0000_0010);
    chk(lineFeat[5], DFS_FEAT_IRQ_COUNT);
    chk(lineFeat[4], DFS_FEAT_QUADRATURE);
    rd(DFS_OFS_STATUS, 32'h0000_0003);
    wr(DFS_OFS_STATUS, 3);
    rd(DFS_OFS_STATUS, 0);
    resA[2] <= 32'hABCD_1234;
    resB[2] <= 32'h5678_9ABC;
    wr(DFS_OFS_LINE_SEL, 2);
    wr(DFS_OFS_FEAT_IDX, DFS_FEAT_HS_COUNTER);
    wr(DFS_OFS_ENABLE, 1);
    host.stall <= 1'b1;
    repeat (2) @(posedge sys_clk);
    host.send(DFS_ENT_RESULT_A, 5'd2);
    host.send(DFS_ENT_CAPTURE, 5'd0);
    host.stop();
    @(negedge sys_clk);
    chk(entryReady, 0);
    // New requests go out just after a rising edge only
    @(posedge sys_clk);
    host.stall <= 1'b0;
    host.send(DFS_ENT_RESULT_B, 5'd2);
    host.send(DFS_ENT_CAPTURE, 5'd0);
    host.send(DFS_ENT_RES_A_CLR, 5'd2);
    host.send(DFS_ENT_CAPTURE, 5'd0);
    host.stop();
    foreach (ex[i]) expw(ex[i]);
    rd(DFS_OFS_RESULT_A, 32'hABCD_1234);
    rd(DFS_OFS_RES_A_CLR, 32'hABCD_1234);
    rd(DFS_OFS_RESULT_B, 32'h5678_9ABC);
    rd(DFS_OFS_CAPTURE, 32'h0000_ABCD);
    chk(clrCnt[2], 2);
    chk(clrCnt[0], 0);
    chk({9'h000, lineEn}, 32'h0000_0014);
    endSim();
  end
endmodule
